// ### logic/sfr_framer.v
// Transmit frame generator: 9 x 90 byte frames with pointer bytes.
// Assumes a 100 MHz clock, synchronous inputs, and a source that holds
// payload bytes steady while PAY_VALID_I is high and PAY_READY_O is low.
`timescale 1ns/1ps
`include "sfr_framer_map.vh"

module sfr_framer #(
    parameter FRAME_CYCLES = `SFR_FRAME_NS / `SFR_CLK_NS
)
(
    input wire CLK_I,
    input wire RST_I,
    input wire [7:0] PAY_DATA_I,
    input wire PAY_VALID_I,
    output reg PAY_READY_O,
    input wire [7:0] OVERHEAD_DATA_I,
    input wire [9:0] POINTER_I,
    input wire NEW_DATA_FLAG_I,
    input wire PTR_INC_I,
    input wire PTR_DEC_I,
    output reg [7:0] LINE_DATA_O,
    output reg LINE_VALID_O,
    output reg FRAME_START_O,
    output reg TRANSPORT_OVERHEAD_O,
    output reg PATH_OVERHEAD_O,
    output reg ENVELOPE_START_O,
    output reg UNDERRUN_O
);

    // ****************************************************************
    // Byte tick
    // ****************************************************************
    reg [14:0] acc;
    wire [15:0] acc_sum;
    wire tick;

    assign acc_sum = {1'b0, acc} + {1'b0, `SFR_FRAME_BYTES};
    assign tick = (acc_sum >= FRAME_CYCLES[15:0]);

    always @(posedge CLK_I)
    begin
        if (RST_I)
            acc <= 15'h0000;
        else if (tick)
            acc <= acc_sum[14:0] - FRAME_CYCLES[14:0];
        else
            acc <= acc_sum[14:0];
    end

    // ****************************************************************
    // Payload buffer
    // ****************************************************************
    reg [7:0] buf_mem [0:1];
    reg wr_ptr;
    reg rd_ptr;
    reg [1:0] count;
    wire push;
    wire pop;
    wire [1:0] next_count;

    assign push = PAY_VALID_I && PAY_READY_O;
    assign next_count = count + {1'b0, push} - {1'b0, pop};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_entry
            always @(posedge CLK_I)
            begin
                if (RST_I)
                    buf_mem[gi] <= 8'h00;
                else if (push && (wr_ptr == gi))
                    buf_mem[gi] <= PAY_DATA_I;
            end
        end
    endgenerate

    always @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
            PAY_READY_O <= 1'b1;
        end
        else
        begin
            if (push)
                wr_ptr <= ~wr_ptr;
            if (pop)
                rd_ptr <= ~rd_ptr;
            count <= next_count;
            PAY_READY_O <= (next_count != 2'h2);
        end
    end

    // ****************************************************************
    // Position counters
    // ****************************************************************
    reg [3:0] row;
    reg [6:0] col;
    reg [9:0] ec_idx;
    reg [6:0] env_col;
    reg env_on;
    reg [9:0] ptr_cur;
    reg new_flag_cur;
    reg inc_cur;
    reg dec_cur;
    wire is_ovh;
    wire is_ec;
    wire row_end;
    wire [9:0] cur_ec;
    wire env_start;
    wire is_path_ovh;
    wire pop_req;

    assign is_ovh = (col < `SFR_OVH_COLS);
    assign is_ec = !is_ovh;
    assign row_end = (col == `SFR_COLS - 7'd1);
    assign cur_ec = (row == `SFR_PTR_ROW && col == `SFR_OVH_COLS) ?
                    10'h000 : ec_idx;
    assign env_start = is_ec && (cur_ec == ptr_cur);
    assign is_path_ovh = is_ec && (env_start || (env_on && env_col == 7'd0));
    // Empty buffer ignores the pop so the count cannot wrap
    assign pop_req = tick && is_ec && (env_on || env_start);
    assign pop = pop_req && (count != 2'h0);

    always @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            row <= 4'd0;
            col <= 7'd0;
        end
        else if (tick)
        begin
            if (row_end)
            begin
                col <= 7'd0;
                if (row == `SFR_ROWS - 4'd1)
                    row <= 4'd0;
                else
                    row <= row + 4'd1;
            end
            else
                col <= col + 7'd1;
        end
    end

    always @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            ec_idx <= `SFR_EC_FIRST;
            env_col <= 7'd0;
            env_on <= 1'b0;
        end
        else if (tick && is_ec)
        begin
            if (cur_ec == `SFR_EC_BYTES - 10'd1)
                ec_idx <= 10'h000;
            else
                ec_idx <= cur_ec + 10'd1;
            if (env_start)
            begin
                env_on <= 1'b1;
                env_col <= 7'd1;
            end
            else if (env_on)
            begin
                if (env_col == `SFR_ENV_COLS - 7'd1)
                    env_col <= 7'd0;
                else
                    env_col <= env_col + 7'd1;
            end
        end
    end

    // ****************************************************************
    // Pointer capture
    // ****************************************************************
    always @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            ptr_cur <= 10'h000;
            new_flag_cur <= 1'b0;
            inc_cur <= 1'b0;
            dec_cur <= 1'b0;
        end
        else if (tick && row == 4'd0 && col == 7'd0)
        begin
            ptr_cur <= POINTER_I;
            new_flag_cur <= NEW_DATA_FLAG_I;
            inc_cur <= PTR_INC_I;
            dec_cur <= PTR_DEC_I && !PTR_INC_I;
        end
    end

    // ****************************************************************
    // Byte selection
    // ****************************************************************
    reg [7:0] next_byte;
    reg [9:0] ptr_word;

    always @*
    begin
        ptr_word = ptr_cur;
        if (inc_cur)
            ptr_word = ptr_cur ^ `SFR_I_MASK;
        else if (dec_cur)
            ptr_word = ptr_cur ^ `SFR_D_MASK;
        next_byte = `SFR_FILL;
        if (is_ovh)
        begin
            next_byte = OVERHEAD_DATA_I;
            if (row == `SFR_PTR_ROW)
            begin
                case (col)
                    `SFR_H1_COL:
                        next_byte = {new_flag_cur ? `SFR_NEWFLAG_ON :
                                     `SFR_NEWFLAG_OFF,
                                     `SFR_SS_BITS, ptr_word[9:8]};
                    `SFR_H2_COL:
                        next_byte = ptr_word[7:0];
                    `SFR_H3_COL:
                        next_byte = `SFR_H3_IDLE;
                    default:
                        next_byte = OVERHEAD_DATA_I;
                endcase
            end
        end
        else if ((env_on || env_start) && count != 2'h0)
            next_byte = buf_mem[rd_ptr];
    end

    // ****************************************************************
    // Line outputs
    // ****************************************************************
    always @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            LINE_DATA_O <= 8'h00;
            LINE_VALID_O <= 1'b0;
            FRAME_START_O <= 1'b0;
            TRANSPORT_OVERHEAD_O <= 1'b0;
            PATH_OVERHEAD_O <= 1'b0;
            ENVELOPE_START_O <= 1'b0;
            UNDERRUN_O <= 1'b0;
        end
        else
        begin
            LINE_VALID_O <= tick;
            LINE_DATA_O <= tick ? next_byte : 8'h00;
            FRAME_START_O <= tick && row == 4'd0 && col == 7'd0;
            TRANSPORT_OVERHEAD_O <= tick && is_ovh;
            PATH_OVERHEAD_O <= tick && is_path_ovh;
            ENVELOPE_START_O <= tick && env_start;
            UNDERRUN_O <= pop_req && count == 2'h0;
        end
    end

endmodule // sfr_framer

// ### pkg/sfr_framer_map.vh
// Constants for the frame generator: frame geometry, pointer byte layout
// and timing. Assumes inclusion by bare name from design files.
`ifndef SFR_FRAMER_MAP_VH
`define SFR_FRAMER_MAP_VH

// ****************************************************************
// Frame geometry
// ****************************************************************
`define SFR_ROWS 4'd9
`define SFR_COLS 7'd90
`define SFR_OVH_COLS 7'd3
`define SFR_ENV_COLS 7'd87
`define SFR_FRAME_BYTES 15'd810
`define SFR_EC_BYTES 10'd783
`define SFR_EC_FIRST 10'd522
`define SFR_PTR_ROW 4'd3
`define SFR_H1_COL 7'd0
`define SFR_H2_COL 7'd1
`define SFR_H3_COL 7'd2

// ****************************************************************
// Pointer bytes
// ****************************************************************
`define SFR_NEWFLAG_OFF 4'h6
`define SFR_NEWFLAG_ON 4'h9
`define SFR_SS_BITS 2'h0
`define SFR_I_MASK 10'h2aa
`define SFR_D_MASK 10'h155
`define SFR_H3_IDLE 8'h00
`define SFR_FILL 8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define SFR_FRAME_NS 125000
`define SFR_CLK_NS 10

`endif

// ### verification/sfr_framer_properties.sv
// Checker on the frame generator ports.
// Assumes it is bound into every frame generator instance.
`timescale 1ns/1ps
module sfr_framer_properties #(
    parameter FRAME_CYCLES = 12500
)
(
    input wire CLK_I,
    input wire RST_I,
    input wire [7:0] LINE_DATA_O,
    input wire LINE_VALID_O,
    input wire FRAME_START_O,
    input wire TRANSPORT_OVERHEAD_O,
    input wire PATH_OVERHEAD_O,
    input wire ENVELOPE_START_O,
    input wire UNDERRUN_O
);
    reg [9:0] cnt;
    reg [15:0] gap;
    reg seen;
    // ********
    // Bytes and cycles per frame
    // ********
    always @(posedge CLK_I)
    begin
        if (RST_I || FRAME_START_O)
        begin
            cnt <= {9'h000, ~RST_I};
            gap <= 16'h0001;
        end
        else
        begin
            cnt <= cnt + {9'h000, LINE_VALID_O};
            gap <= gap + 16'h0001;
        end
        seen <= ~RST_I & (seen | FRAME_START_O);
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    property p_len; FRAME_START_O && seen |-> cnt == 10'h32a; endproperty
    a_len: assert property (p_len) else $error("length");
    property p_rate; FRAME_START_O && seen |-> gap == FRAME_CYCLES; endproperty
    a_rate: assert property (p_rate) else $error("rate");
    property p_gap; LINE_VALID_O |-> ##[1:16] LINE_VALID_O; endproperty
    a_gap: assert property (p_gap) else $error("gap");
    property p_once; FRAME_START_O |=> !FRAME_START_O [*8]; endproperty
    a_once: assert property (p_once) else $error("start");
    property p_fs;
        FRAME_START_O |-> TRANSPORT_OVERHEAD_O && LINE_VALID_O;
    endproperty
    a_fs: assert property (p_fs) else $error("first");
    property p_ovh;
        TRANSPORT_OVERHEAD_O |-> LINE_VALID_O && !PATH_OVERHEAD_O &&
            !UNDERRUN_O;
    endproperty
    a_ovh: assert property (p_ovh) else $error("overhead");
    property p_idle;
        !LINE_VALID_O |-> LINE_DATA_O == 8'h00 && !PATH_OVERHEAD_O;
    endproperty
    a_idle: assert property (p_idle) else $error("idle");
    property p_env;
        ENVELOPE_START_O |-> PATH_OVERHEAD_O && LINE_VALID_O;
    endproperty
    a_env: assert property (p_env) else $error("envelope");
endmodule // sfr_framer_properties

bind sfr_framer sfr_framer_properties #(.FRAME_CYCLES(FRAME_CYCLES)) u_props (
    .CLK_I(CLK_I), .RST_I(RST_I), .LINE_DATA_O(LINE_DATA_O),
    .LINE_VALID_O(LINE_VALID_O), .FRAME_START_O(FRAME_START_O),
    .TRANSPORT_OVERHEAD_O(TRANSPORT_OVERHEAD_O),
    .PATH_OVERHEAD_O(PATH_OVERHEAD_O),
    .ENVELOPE_START_O(ENVELOPE_START_O),
    .UNDERRUN_O(UNDERRUN_O));

// ### verification/sfr_line_sink.sv
// Line side model: byte position, frame length, pointer bytes.
// Assumes one-cycle byte strobes and a start mark on byte 0.
`timescale 1ns/1ps
module sfr_line_sink
(
    input wire clk_i,
    input wire valid_i,
    input wire fs_i,
    input wire [7:0] data_i,
    output reg [9:0] pos_o,
    output reg [9:0] len_o,
    output reg [23:0] ptr_o
);
    // ********
    // Position and pointer capture
    // ********
    always @(posedge clk_i)
    begin
        if (valid_i)
            pos_o <= fs_i ? 10'h000 : pos_o + 10'h001;
        if (valid_i && fs_i)
            len_o <= pos_o + 10'h001;
        if (valid_i && pos_o >= 10'h10d && pos_o <= 10'h10f)
            ptr_o <= {ptr_o[15:0], data_i};
    end
endmodule // sfr_line_sink

// ### verification/tb_top.sv
// Testbench: frame layout, pointer modes, buffer stalls.
// Assumes the design, checker and line model are compiled first.
`timescale 1ns/1ps
module tb_top;
    localparam FC = 1620;
    reg clk = 1'b0, rst = 1'b1, pay_v = 1'b0, new_flag = 1'b0, inc = 1'b0;
    reg dec = 1'b0, src_en = 1'b0, took = 1'b0, env_seen = 1'b0, chk = 1'b0;
    reg [7:0] pay = 8'h00, ovh_byte = 8'h5a, exp_pay = 8'h00;
    reg [6:0] env_col = 7'd0;
    reg [9:0] ptr = 10'h000, env_pos = 10'h000;
    integer mismatches = 0, comparisons = 0, under = 0, full = 0, i;
    wire rdy, lv, fs, ovh, path_ovh, env, und;
    wire [7:0] ld;
    wire [9:0] pos, len;
    wire [23:0] pb;
    wire [9:0] idx = fs ? 10'h000 : pos + 10'h001;
    sfr_framer #(.FRAME_CYCLES(FC)) u_dut (.CLK_I(clk), .RST_I(rst),
        .PAY_DATA_I(pay), .PAY_VALID_I(pay_v), .PAY_READY_O(rdy),
        .OVERHEAD_DATA_I(ovh_byte), .POINTER_I(ptr),
        .NEW_DATA_FLAG_I(new_flag), .PTR_INC_I(inc), .PTR_DEC_I(dec),
        .LINE_DATA_O(ld), .LINE_VALID_O(lv), .FRAME_START_O(fs),
        .TRANSPORT_OVERHEAD_O(ovh), .PATH_OVERHEAD_O(path_ovh),
        .ENVELOPE_START_O(env), .UNDERRUN_O(und));
    sfr_line_sink u_sink (.clk_i(clk), .valid_i(lv), .fs_i(fs), .data_i(ld),
        .pos_o(pos), .len_o(len), .ptr_o(pb));
    // ********
    // Clock, source and monitor
    // ********
    initial
        forever #5 clk = ~clk;
    always @(posedge clk)
        took <= pay_v & rdy;
    always @(negedge clk)
    begin
        if (took)
            pay <= pay + 8'h01;
        if (!pay_v || took)
            pay_v <= src_en;
        full <= full + (pay_v & !rdy);
        under <= under + und;
        if (env)
            env_pos <= idx;
        if (lv && chk)
        begin
            check(ovh, idx % 90 < 3);
            if (ovh && (idx < 270 || idx > 272))
                check(ld, ovh_byte);
            ovh_byte <= ovh_byte + 8'h01;
        end
        if (lv && !ovh && (env || env_seen))
        begin
            check(path_ovh, env || env_col == 7'd0);
            if (env || env_col == 7'd86)
                env_col <= env ? 7'd1 : 7'd0;
            else
                env_col <= env_col + 7'd1;
        end
        if (lv && !ovh && !und && (env || env_seen))
        begin
            check(ld, exp_pay);
            exp_pay <= exp_pay + 8'h01;
            env_seen <= 1'b1;
        end
    end
    task check(input [23:0] seen, input [23:0] want);
    begin
        comparisons = comparisons + 1;
        if (seen !== want)
        begin
            mismatches = mismatches + 1;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    end
    endtask
    task wait_fs;
    begin
        i = 0;
        @(negedge clk);
        while (fs !== 1'b1 && i < 2000)
        begin
            @(negedge clk);
            i = i + 1;
        end
        check(fs, 1'b1);
    end
    endtask
    task t_frame(input [9:0] p, input n, input a, input d);
        reg [9:0] v;
    begin
        v = p ^ (a ? 10'h2aa : d ? 10'h155 : 10'h000);
        wait_fs;
        ptr = p;
        new_flag = n;
        inc = a;
        dec = d;
        wait_fs;
        wait_fs;
        check(len, 10'h32a);
        check(env_pos, ((p / 87 + 3) % 9) * 90 + 3 + p % 87);
        check(pb, {n ? 4'h9 : 4'h6, 2'b00, v, 8'h00});
    end
    endtask
    task t_starve;
    begin
        check(full > 0, 1'b1);
        src_en = 1'b0;
        wait_fs;
        wait_fs;
        check(under > 0, 1'b1);
        src_en = 1'b1;
        wait_fs;
        wait_fs;
    end
    endtask
    task wrap_up;
    begin
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        src_en = 1'b1;
        wait_fs;
        chk = 1'b1;
        t_frame(10'h000, 1'b0, 1'b0, 1'b0);
        t_frame(10'h1f4, 1'b1, 1'b0, 1'b0);
        t_frame(10'h30e, 1'b0, 1'b1, 1'b1);
        t_frame(10'h056, 1'b0, 1'b0, 1'b1);
        t_starve;
        wrap_up;
    end
    initial
    begin
        #(FC * 10 * 30);
        mismatches = mismatches + 1;
        wrap_up;
    end
endmodule // tb_top
